// [hw/mas_pkg.sv]
// shared constants and mode types for the multiply-add output stage
// Function
// - saturation modes none, symmetric, asymmetric
// - symmetric clamp: negative limit equals positive limit
// - asymmetric clamp: negative limit one beyond positive
// - overflow output comes from saturation unit
// - optional input registers, forced with shift-in
// - optional register after the multipliers
// - optional adder register, forced in accumulator mode
// - optional register after the chainout adder
// - optional register on the shift-out output
// - pipeline registers update only while enable is high; the output buffer still drains
// - asynchronous clear resets all pipeline registers and empties the output buffer; buffer storage is not reset
// - combine-clears on: user clear OR global clear
// - combine-clears off: global clear ignored
// - combine-clears defaults on, needs user clear
// - data and sign inputs are vectors; clear, enable, load and zero controls single bits
// - full result width 2L plus log2 n bits
// - signed buses carry sign in the msb
// - rounding: truncate, nearest integer, nearest even
// - chain output replaces normal result when selected
package mas_pkg;
    localparam int IN_W     = 18;                 // integer bits per operand, no fraction
    localparam int N_MUL    = 4;                  // multipliers feeding the adder
    localparam int MUL_LOG  = 2;                  // ceil(log2(N_MUL))
    localparam int EXT_W    = IN_W + 1;           // operand with explicit sign bit
    localparam int PROD_W   = 2 * EXT_W;          // one product
    localparam int FULL_W   = 2 * IN_W + MUL_LOG; // full resolution sum width
    localparam int SUM_W    = PROD_W + MUL_LOG;   // sum of all products
    localparam int ACC_W    = 44;                 // accumulator and chain width
    localparam int OUT_LSB  = 4;                  // result lsb position for rounding
    localparam int OUT_W    = 24;                 // saturated result width
    localparam int Q_W      = ACC_W - OUT_LSB + 1;// rounded value before clamp
    localparam int FIFO_DEP = 16;                 // output buffer depth
    localparam int FIFO_W   = ACC_W + 1;          // result word plus overflow flag

    // clamp limits at rounded width
    localparam logic signed [Q_W-1:0] SAT_POS =
        {{(Q_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
    localparam logic signed [Q_W-1:0] SAT_NEG_SYM  = -SAT_POS;
    localparam logic signed [Q_W-1:0] SAT_NEG_ASYM = SAT_NEG_SYM - {{(Q_W-1){1'b0}}, 1'b1};
    // half of one output lsb, used for rounding
    localparam logic [ACC_W:0] RND_HALF =
        {{(ACC_W-OUT_LSB+1){1'b0}}, 1'b1, {(OUT_LSB-1){1'b0}}};
    localparam logic [ACC_W:0] RND_HALF_M1 = RND_HALF - {{ACC_W{1'b0}}, 1'b1};

    typedef enum logic [2:0] {
        MAS_SAT_WRAP = 3'h1,
        MAS_SAT_SYM  = 3'h2,
        MAS_SAT_ASYM = 3'h4
    } mas_sat_type;

    typedef enum logic [2:0] {
        MAS_RND_TRUNC   = 3'h1,
        MAS_RND_NEAREST = 3'h2,
        MAS_RND_EVEN    = 3'h4
    } mas_rnd_type;
endpackage

// [hw/mas_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module mas_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             clr_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];   // storage array
    logic [AW-1:0]    wr_ptr_ff;        // next slot to write
    logic [AW-1:0]    rd_ptr_ff;        // oldest slot
    logic [AW:0]      count_ff;         // words held
    logic             push_w;           // accepted write
    logic             pop_w;            // accepted read

    // full and empty straight from the count, no guessing
    assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (count_ff != {(AW+1){1'b0}});
    assign push_w      = in_valid_i & in_ready_o;
    assign pop_w       = out_valid_o & out_ready_i;
    assign out_data_o  = mem_ff[rd_ptr_ff];

    // storage has no reset, only pointers do
    always_ff @(posedge clock_i) begin
        if (push_w) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // pointers and count; clear empties the buffer
    always_ff @(posedge clock_i or posedge clr_i) begin
        if (clr_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push_w) wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            if (pop_w)  rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            count_ff <= count_ff + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
        end
    end
endmodule

// [hw/mas_stage.sv]
// multiply-add datapath with rounding, saturation and output buffer
`timescale 1ns/1ps
module mas_stage
    import mas_pkg::*;
#(
    parameter bit REG_IN       = 1'b1,  // register multiplier inputs
    parameter bit REG_MUL      = 1'b1,  // register multiplier outputs
    parameter bit REG_ADD      = 1'b1,  // register adder output
    parameter bit REG_CHAIN    = 1'b1,  // register chainout adder output
    parameter bit REG_SHOUT    = 1'b1,  // register shift-out output
    parameter bit SHIFTIN      = 1'b0,  // operand a from previous multiplier
    parameter bit ACCUM        = 1'b0,  // accumulator mode
    parameter bit ACC_SUB      = 1'b0,  // accumulator subtracts
    parameter bit SUB_PAIR0    = 1'b0,  // first pair subtracts second product
    parameter bit SUB_PAIR1    = 1'b0,  // second pair subtracts fourth product
    parameter bit USE_CHAININ  = 1'b0,  // add chain input
    parameter bit USE_CHAINOUT = 1'b0,  // present chain value instead of result
    parameter bit USE_ENA      = 1'b1,  // honour enable input
    parameter bit USE_ACLR     = 1'b1,  // honour user clear input
    parameter bit OR_GCLR      = 1'b1   // combine user and global clear
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    input  wire logic                  aclr_i,
    input  wire logic                  gclr_i,
    input  wire logic                  ena_i,
    input  wire logic                  in_valid_i,
    output logic                       in_ready_o,
    input  wire logic [N_MUL-1:0][IN_W-1:0] a_i,
    input  wire logic [N_MUL-1:0][IN_W-1:0] b_i,
    input  wire logic [N_MUL-1:0]      sign_a_i,
    input  wire logic [N_MUL-1:0]      sign_b_i,
    input  wire logic                  accum_sload_i,
    input  wire logic [ACC_W-1:0]      chainin_i,
    input  wire logic                  zero_chainout_i,
    input  wire mas_sat_type           sat_mode_i,
    input  wire mas_rnd_type           rnd_mode_i,
    output logic                       out_valid_o,
    input  wire logic                  out_ready_i,
    output logic [ACC_W-1:0]           result_o,
    output logic                       overflow_o,
    output logic [IN_W-1:0]            shiftout_o
);
    // a shift chain needs stored operands; accumulation needs a stored sum
    localparam bit REG_IN_EFF  = REG_IN | SHIFTIN;
    localparam bit REG_ADD_EFF = REG_ADD | ACCUM;

    // operand extension: msb is the sign when the control bit is set
    function automatic logic signed [EXT_W-1:0] ext_op(input logic [IN_W-1:0] v,
                                                      input logic is_signed);
        ext_op = {is_signed & v[IN_W-1], v};
    endfunction

    // widen a signed value to the accumulator width
    function automatic logic signed [ACC_W-1:0] to_acc(input logic signed [SUM_W-1:0] v);
        to_acc = {{(ACC_W-SUM_W){v[SUM_W-1]}}, v};
    endfunction

    // ---------------- clears, enable, advance ----------------
    logic clr_w;        // combined asynchronous clear
    logic adv_w;        // pipeline moves this edge
    logic ena_w;        // effective enable
    logic fifo_rdy_w;   // buffer has room

    // global clear joins only when the user clear exists and combining is on
    assign clr_w = USE_ACLR & (aclr_i | (OR_GCLR & gclr_i));
    assign ena_w = USE_ENA ? ena_i : 1'b1;
    // a full buffer freezes the whole pipe, so nothing in flight is lost
    assign adv_w      = ena_w & fifo_rdy_w;
    assign in_ready_o = adv_w;

    // ---------------- stage 0: multiplier inputs ----------------
    logic [N_MUL-1:0][IN_W-1:0] a_in_w;   // operand a before input register
    logic [N_MUL-1:0][IN_W-1:0] a_r_ff;   // registered operand a
    logic [N_MUL-1:0][IN_W-1:0] b_r_ff;   // registered operand b
    logic [N_MUL-1:0]           sa_r_ff;  // registered sign controls
    logic [N_MUL-1:0]           sb_r_ff;
    logic                       v0_ff;    // stage 0 valid
    logic [N_MUL-1:0][IN_W-1:0] a_s0;     // stage 0 outputs
    logic [N_MUL-1:0][IN_W-1:0] b_s0;
    logic [N_MUL-1:0]           sa_s0;
    logic [N_MUL-1:0]           sb_s0;
    logic                       v0_s;

    // shift chain feeds each multiplier after the first from the previous stored operand
    assign a_in_w[0] = a_i[0];
    for (genvar k = 1; k < N_MUL; k++) begin : g_shift
        assign a_in_w[k] = SHIFTIN ? a_r_ff[k-1] : a_i[k];
    end

    // input register bank
    always_ff @(posedge clock_i or posedge clr_w) begin
        if (clr_w) begin
            a_r_ff  <= '0;
            b_r_ff  <= '0;
            sa_r_ff <= '0;
            sb_r_ff <= '0;
            v0_ff   <= 1'b0;
        end else if (rst_i) begin
            a_r_ff  <= '0;
            b_r_ff  <= '0;
            sa_r_ff <= '0;
            sb_r_ff <= '0;
            v0_ff   <= 1'b0;
        end else if (adv_w) begin
            a_r_ff  <= a_in_w;
            b_r_ff  <= b_i;
            sa_r_ff <= sign_a_i;
            sb_r_ff <= sign_b_i;
            v0_ff   <= in_valid_i;
        end
    end

    // bypass when the input register is not built
    assign a_s0  = REG_IN_EFF ? a_r_ff  : a_in_w;
    assign b_s0  = REG_IN_EFF ? b_r_ff  : b_i;
    assign sa_s0 = REG_IN_EFF ? sa_r_ff : sign_a_i;
    assign sb_s0 = REG_IN_EFF ? sb_r_ff : sign_b_i;
    assign v0_s  = REG_IN_EFF ? v0_ff   : in_valid_i;

    // ---------------- stage 1: multipliers ----------------
    logic signed [PROD_W-1:0] prod_w  [N_MUL];  // raw products
    logic signed [PROD_W-1:0] prod_ff [N_MUL];  // registered products
    logic signed [PROD_W-1:0] p_s1    [N_MUL];  // stage 1 outputs
    logic                     v1_ff;
    logic                     v1_s;

    for (genvar k = 0; k < N_MUL; k++) begin : g_mul
        assign prod_w[k] = ext_op(a_s0[k], sa_s0[k]) * ext_op(b_s0[k], sb_s0[k]);
        assign p_s1[k]   = REG_MUL ? prod_ff[k] : prod_w[k];
    end

    // product register bank
    always_ff @(posedge clock_i or posedge clr_w) begin
        if (clr_w) begin
            prod_ff <= '{default: '0};
            v1_ff   <= 1'b0;
        end else if (rst_i) begin
            prod_ff <= '{default: '0};
            v1_ff   <= 1'b0;
        end else if (adv_w) begin
            prod_ff <= prod_w;
            v1_ff   <= v0_s;
        end
    end
    assign v1_s = REG_MUL ? v1_ff : v0_s;

    // ---------------- stage 2: adder and accumulator ----------------
    logic signed [SUM_W-1:0] pair0_w;   // first pair result
    logic signed [SUM_W-1:0] pair1_w;   // second pair result
    logic signed [SUM_W-1:0] sum_w;     // all products, full resolution
    logic signed [ACC_W-1:0] acc_base_w;// previous sum or zero on load
    logic signed [ACC_W-1:0] nxt_add;   // adder result to store
    logic signed [ACC_W-1:0] add_ff;    // adder / accumulator register
    logic signed [ACC_W-1:0] add_s2;    // stage 2 output
    logic                    v2_ff;
    logic                    v2_s;

    // sign extension keeps the full-resolution sum exact
    assign pair0_w = SUB_PAIR0 ? SUM_W'(p_s1[0]) - SUM_W'(p_s1[1])
                               : SUM_W'(p_s1[0]) + SUM_W'(p_s1[1]);
    assign pair1_w = SUB_PAIR1 ? SUM_W'(p_s1[2]) - SUM_W'(p_s1[3])
                               : SUM_W'(p_s1[2]) + SUM_W'(p_s1[3]);
    assign sum_w   = pair0_w + pair1_w;

    // synchronous load restarts the running sum from zero
    assign acc_base_w = (ACCUM && !accum_sload_i) ? add_ff : '0;
    assign nxt_add    = (ACCUM && ACC_SUB) ? acc_base_w - to_acc(sum_w)
                                           : acc_base_w + to_acc(sum_w);

    // adder register; accumulation counts only valid words
    always_ff @(posedge clock_i or posedge clr_w) begin
        if (clr_w) begin
            add_ff <= '0;
            v2_ff  <= 1'b0;
        end else if (rst_i) begin
            add_ff <= '0;
            v2_ff  <= 1'b0;
        end else if (adv_w) begin
            if (v1_s || !ACCUM) begin
                add_ff <= nxt_add;
            end
            v2_ff <= v1_s;
        end
    end
    assign add_s2 = REG_ADD_EFF ? add_ff : nxt_add;
    assign v2_s   = REG_ADD_EFF ? v2_ff  : v1_s;

    // ---------------- stage 3: chainout adder ----------------
    logic signed [ACC_W-1:0] chain_w;   // chainout adder result
    logic signed [ACC_W-1:0] chain_ff;  // registered chain result
    logic signed [ACC_W-1:0] res_s3;    // value entering the output unit
    logic                    v3_ff;
    logic                    v3_s;

    // zero request overrides the chain value for this word
    assign chain_w = zero_chainout_i ? '0
                   : add_s2 + (USE_CHAININ ? $signed(chainin_i) : '0);

    // chainout register bank
    always_ff @(posedge clock_i or posedge clr_w) begin
        if (clr_w) begin
            chain_ff <= '0;
            v3_ff    <= 1'b0;
        end else if (rst_i) begin
            chain_ff <= '0;
            v3_ff    <= 1'b0;
        end else if (adv_w) begin
            chain_ff <= chain_w;
            v3_ff    <= v2_s;
        end
    end
    assign res_s3 = REG_CHAIN ? chain_ff : chain_w;
    assign v3_s   = REG_CHAIN ? v3_ff    : v2_s;

    // ---------------- rounding and saturation ----------------
    logic        [ACC_W:0]   ext_w;     // result with a guard bit
    logic        [ACC_W:0]   rnd_add_w; // rounding increment
    logic        [ACC_W:0]   rnd_w;     // rounded, before shift
    logic signed [Q_W-1:0]   q_w;       // rounded at output lsb
    logic signed [Q_W-1:0]   neg_lim_w; // active negative limit
    logic                    hi_w;      // above positive limit
    logic                    lo_w;      // below negative limit
    logic                    clamp_w;   // saturation acted
    logic signed [Q_W-1:0]   sat_w;     // clamped or wrapped value
    logic [ACC_W-1:0]        word_w;    // word placed in the buffer

    assign ext_w = {res_s3[ACC_W-1], res_s3};
    // nearest even adds one less than half unless the kept lsb is odd
    assign rnd_add_w = (rnd_mode_i == MAS_RND_NEAREST) ? RND_HALF :
                       (rnd_mode_i == MAS_RND_EVEN)
                           ? (ext_w[OUT_LSB] ? RND_HALF : RND_HALF_M1)
                           : '0;
    assign rnd_w = ext_w + rnd_add_w;
    assign q_w   = $signed(rnd_w[ACC_W:OUT_LSB]);

    // the two clamp flavours differ only in the negative limit
    assign neg_lim_w = (sat_mode_i == MAS_SAT_ASYM) ? SAT_NEG_ASYM : SAT_NEG_SYM;
    assign hi_w      = q_w > SAT_POS;
    assign lo_w      = q_w < neg_lim_w;
    // wrap mode clamps nothing, so it never flags
    assign clamp_w   = (sat_mode_i != MAS_SAT_WRAP) & (hi_w | lo_w);
    assign sat_w     = !clamp_w ? q_w : (hi_w ? SAT_POS : neg_lim_w);

    // wrap keeps the low bits; the result is sign-extended from the msb
    assign word_w = USE_CHAINOUT ? res_s3
                  : {{(ACC_W-OUT_W){sat_w[OUT_W-1]}}, sat_w[OUT_W-1:0]};

    // ---------------- output buffer ----------------
    logic [FIFO_W-1:0] fifo_out_w;  // flag and word leaving the buffer

    // overflow travels in the same word as its result, so they stay aligned
    mas_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEP)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .clr_i       (clr_w),
        .in_valid_i  (v3_s & ena_w),
        .in_ready_o  (fifo_rdy_w),
        .in_data_i   ({clamp_w & !USE_CHAINOUT, word_w}),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (fifo_out_w)
    );
    assign result_o   = fifo_out_w[ACC_W-1:0];
    assign overflow_o = fifo_out_w[ACC_W];

    // ---------------- shift-out ----------------
    logic [IN_W-1:0] shout_ff;   // registered last operand a

    // last multiplier's operand a, optionally delayed one more stage
    always_ff @(posedge clock_i or posedge clr_w) begin
        if (clr_w) begin
            shout_ff <= '0;
        end else if (rst_i) begin
            shout_ff <= '0;
        end else if (adv_w) begin
            shout_ff <= a_s0[N_MUL-1];
        end
    end
    // limitation: without input registers the unregistered path is combinational
    assign shiftout_o = REG_SHOUT ? shout_ff : a_s0[N_MUL-1];
endmodule

// [sim/mas_stage_checker.sv]
// assertion checker bound to the multiply-add output stage
`timescale 1ns/1ps
module mas_stage_checker
    import mas_pkg::*;
#(
    parameter bit USE_ACLR = 1'b1,  // user clear honoured
    parameter bit OR_GCLR  = 1'b1   // global clear joins user clear
) (
    input wire logic                       clock_i,
    input wire logic                       rst_i,
    input wire logic                       aclr_i,
    input wire logic                       gclr_i,
    input wire logic                       ena_i,
    input wire logic                       in_valid_i,
    input wire logic                       in_ready_o,
    input wire logic [N_MUL-1:0][IN_W-1:0] a_i,
    input wire logic                       out_valid_o,
    input wire logic                       out_ready_i,
    input wire logic [ACC_W-1:0]           result_o,
    input wire logic                       overflow_o,
    input wire logic [IN_W-1:0]            shiftout_o
);
    default clocking @(posedge clock_i); endclocking
    wire logic            clr_any = aclr_i || gclr_i; // either clear, async
    wire logic [IN_W-1:0] a_last  = a_i[N_MUL-1];     // operand feeding shift-out

    ready_needs_ena_a: assert property (disable iff (rst_i) !ena_i |-> !in_ready_o)
        else $error("ready high while enable low");
    shift_hold_a: assert property (disable iff (rst_i || clr_any) !ena_i |=> $stable(shiftout_o))
        else $error("shift-out moved while enable low");
    shift_path_a: assert property (disable iff (rst_i || clr_any) in_ready_o ##1 in_ready_o |=> shiftout_o == $past(a_last, 2))
        else $error("shift-out not two stages behind operand");
    five_stage_a: assert property (disable iff (rst_i || clr_any) (in_valid_i && in_ready_o && !out_valid_o ##1 ena_i [*4]) |=> out_valid_o)
        else $error("result missing after five edges");
    aclr_empty_a: assert property (disable iff (rst_i) (USE_ACLR && aclr_i) |-> !out_valid_o)
        else $error("user clear left a word");
    gclr_empty_a: assert property (disable iff (rst_i) (USE_ACLR && OR_GCLR && gclr_i) |-> !out_valid_o)
        else $error("global clear left a word");
    clamp_value_a: assert property (disable iff (rst_i || clr_any) (out_valid_o && overflow_o) |->
        ($signed(result_o) == SAT_POS || $signed(result_o) == SAT_NEG_SYM || $signed(result_o) == SAT_NEG_ASYM))
        else $error("flagged result is not a limit");
    sign_ext_a: assert property (disable iff (rst_i || clr_any) out_valid_o |->
        (&result_o[ACC_W-1:OUT_W-1] || ~|result_o[ACC_W-1:OUT_W-1]))
        else $error("result not sign extended");
    head_hold_a: assert property (disable iff (rst_i || clr_any) (out_valid_o && !out_ready_i) |=>
        (out_valid_o && $stable(result_o) && $stable(overflow_o)))
        else $error("head word changed while stalled");
endmodule
bind mas_stage mas_stage_checker #(.USE_ACLR(USE_ACLR), .OR_GCLR(OR_GCLR)) mas_stage_checker_inst (
    .clock_i(clock_i), .rst_i(rst_i), .aclr_i(aclr_i), .gclr_i(gclr_i), .ena_i(ena_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .a_i(a_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .result_o(result_o), .overflow_o(overflow_o), .shiftout_o(shiftout_o));

// [sim/mas_sink_model.sv]
// downstream datapath model taking result words promptly or with stalls
`timescale 1ns/1ps
module mas_sink_model (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic stall_i,  // refuse every word
    input  wire logic slow_i,   // take every other cycle
    output logic      ready_o
);
    logic toggle_ff;  // pace for slow mode
    logic ready_ff;   // registered like a real neighbour
    logic nxt_ready;
    assign nxt_ready = !stall_i && (!slow_i || toggle_ff);
    assign ready_o   = ready_ff;
    // ready changes only after an edge
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            toggle_ff <= 1'b0;
            ready_ff  <= 1'b0;
        end else begin
            toggle_ff <= !toggle_ff;
            ready_ff  <= nxt_ready;
        end
    end
endmodule

// [sim/mas_stage_tb.sv]
// self-checking bench for the multiply-add output stage
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_total++; $display("unexpected %s exp=%h got=%h", nm, ex, gt); end end
module mas_stage_tb
    import mas_pkg::*;
;
    logic                       clock_i    = 1'b0;
    logic                       rst_i      = 1'b1;
    logic                       aclr_i     = 1'b0;
    logic                       gclr_i     = 1'b0;
    logic                       ena_i      = 1'b1;
    logic                       in_valid_i = 1'b0;
    logic [N_MUL-1:0][IN_W-1:0] a_i        = '0;
    logic [N_MUL-1:0][IN_W-1:0] b_i        = '0;
    logic [N_MUL-1:0]           sign_a_i   = '0;
    mas_sat_type                sat_mode_i = MAS_SAT_WRAP;
    mas_rnd_type                rnd_mode_i = MAS_RND_TRUNC;
    logic                       stall      = 1'b1;  // sink refuses
    logic                       slow       = 1'b0;  // sink takes every other cycle
    logic                       in_ready_o, out_valid_o, out_ready_i, overflow_o;
    logic [ACC_W-1:0]           result_o;
    logic [IN_W-1:0]            shiftout_o;
    logic [ACC_W:0]             exp_q[$];           // overflow flag, result
    int                         err_total  = 0;
    int                         n_checks   = 0;
    // operand table: ties, mid range, overflow both ways, unsigned
    logic [IN_W-1:0] va[6] = '{18'h00001, 18'h00003, 18'h00123, 18'h1ffff, 18'h20000, 18'h3ffff};
    logic [IN_W-1:0] vb[6] = '{18'h00008, 18'h00008, 18'h00045, 18'h1ffff, 18'h1ffff, 18'h00001};
    logic [5:0]      vall  = 6'h1c;  // vector uses all four multipliers
    logic [5:0]      vsg   = 6'h1f;  // vector is signed
    mas_sat_type     sats[3] = '{MAS_SAT_WRAP, MAS_SAT_SYM, MAS_SAT_ASYM};
    mas_rnd_type     rnds[3] = '{MAS_RND_TRUNC, MAS_RND_NEAREST, MAS_RND_EVEN};

    // 18-bit operands throughout, as chained use requires
    mas_stage mas_stage_inst (
        .clock_i(clock_i), .rst_i(rst_i), .aclr_i(aclr_i), .gclr_i(gclr_i), .ena_i(ena_i),
        .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .a_i(a_i), .b_i(b_i), .sign_a_i(sign_a_i),
        .sign_b_i(sign_a_i), .accum_sload_i(1'b0), .chainin_i('0), .zero_chainout_i(1'b0),
        .sat_mode_i(sat_mode_i), .rnd_mode_i(rnd_mode_i), .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i), .result_o(result_o), .overflow_o(overflow_o), .shiftout_o(shiftout_o));
    mas_sink_model mas_sink_model_inst (
        .clock_i(clock_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow), .ready_o(out_ready_i));

    always #12.5 clock_i = ~clock_i;

    // reference: sum of products, round at the result lsb, clamp or wrap
    function automatic logic [ACC_W:0] model(input logic [N_MUL-1:0][IN_W-1:0] a, b, input logic [N_MUL-1:0] sg);
        longint s, q, lim, lo;
        logic   ov;
        s = 0;
        for (int i = 0; i < N_MUL; i++)
            s += (sg[i] ? longint'($signed(a[i])) : longint'(a[i])) * (sg[i] ? longint'($signed(b[i])) : longint'(b[i]));
        lim = (longint'(1) <<< (OUT_W - 1)) - 1;
        if (rnd_mode_i == MAS_RND_NEAREST)
            s += longint'(1) <<< (OUT_LSB - 1);
        else if (rnd_mode_i == MAS_RND_EVEN)
            s += (longint'(1) <<< (OUT_LSB - 1)) - longint'(!s[OUT_LSB]);
        q = s >>> OUT_LSB;
        lo = (sat_mode_i == MAS_SAT_ASYM) ? -lim - 1 : -lim;
        ov = (sat_mode_i != MAS_SAT_WRAP) && (q > lim || q < lo);
        if (sat_mode_i == MAS_SAT_WRAP)
            q = longint'($signed(q[OUT_W-1:0]));
        else if (q > lim)
            q = lim;
        else if (q < lo)
            q = lo;
        return {ov, q[ACC_W-1:0]};
    endfunction

    // present one table vector, hold it until taken
    task automatic send(input int v);
        int t;
        t = 0;
        @(negedge clock_i);
        a_i = vall[v] ? {N_MUL{va[v]}} : {{((N_MUL - 1) * IN_W){1'b0}}, va[v]};
        b_i = vall[v] ? {N_MUL{vb[v]}} : {{((N_MUL - 1) * IN_W){1'b0}}, vb[v]};
        sign_a_i = {N_MUL{vsg[v]}};
        in_valid_i = 1'b1;
        while (!in_ready_o && t < 500) begin
            @(negedge clock_i);
            t++;
        end
        @(posedge clock_i);
        `CHK("taken in time", 1'b1, t < 500)
        exp_q.push_back(model(a_i, b_i, sign_a_i));
    endtask

    // stop offering, wait for every expected word
    task automatic drain();
        int t = 0;
        @(negedge clock_i);
        in_valid_i = 1'b0;
        while (exp_q.size() != 0 && t < 2000) begin
            @(posedge clock_i);
            t++;
        end
        @(negedge clock_i);
        `CHK("words left", 0, exp_q.size())
    endtask

    task automatic stop_test();
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // compare each word the sink takes, in order
    always @(posedge clock_i) begin
        if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            if (exp_q.size() == 0)
                `CHK("extra word", 1'b0, 1'b1)
            else begin
                `CHK("result", exp_q[0][ACC_W-1:0], result_o)
                `CHK("overflow", exp_q[0][ACC_W], overflow_o)
                void'(exp_q.pop_front());
            end
        end
    end

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (40000) @(posedge clock_i);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        stall = 1'b0;
        slow = 1'b1;
        // every mode pair over the table; rounding only with saturation
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                if (sats[i] == MAS_SAT_WRAP && rnds[j] != MAS_RND_TRUNC)
                    continue;
                @(negedge clock_i);
                sat_mode_i = sats[i];
                rnd_mode_i = rnds[j];
                for (int v = 0; v < 6; v++)
                    send(v);
                drain();
            end
        end
        // fill buffer and pipeline against a stalled sink, then drain slowly
        stall = 1'b1;
        repeat (FIFO_DEP + 4) send(2);
        @(negedge clock_i);
        `CHK("accepted", FIFO_DEP + 4, exp_q.size())
        `CHK("full refuses", 1'b0, in_ready_o)
        stall = 1'b0;
        drain();
        `CHK("empty", 1'b0, out_valid_o)
        // enable low freezes the word in flight
        send(3);
        @(negedge clock_i);
        in_valid_i = 1'b0;
        ena_i = 1'b0;
        repeat (8) @(negedge clock_i);
        `CHK("frozen", 1'b0, out_valid_o)
        `CHK("ready off", 1'b0, in_ready_o)
        ena_i = 1'b1;
        drain();
        `CHK("shift-out", a_i[N_MUL-1], shiftout_o)
        // each clear empties the buffer at once, and it stays empty
        for (int k = 0; k < 2; k++) begin
            stall = 1'b1;
            repeat (3) send(2);
            @(negedge clock_i);
            in_valid_i = 1'b0;
            repeat (8) @(negedge clock_i);
            `CHK("held", 1'b1, out_valid_o)
            if (k == 0)
                aclr_i = 1'b1;
            else
                gclr_i = 1'b1;
            #2;
            `CHK("cleared", 1'b0, out_valid_o)
            @(negedge clock_i);
            aclr_i = 1'b0;
            gclr_i = 1'b0;
            exp_q.delete();
            stall = 1'b0;
            repeat (8) @(negedge clock_i);
            `CHK("stays empty", 1'b0, out_valid_o)
        end
        stop_test();
    end
endmodule
